/* rbdi_pkg.sv */
// Package: offsets, field layout and fixed codes of the register block decoder
package rbdi_pkg;
  localparam int ADDR_W = 16;
  localparam int OFFS_W = 10;
  localparam logic [7:0] RESERVED_READ = 8'h00;
  localparam logic [7:0] UNPRED_READ = 8'h00;
  localparam logic [9:0] OFF_BASE = 10'h011;
  localparam logic [9:0] OFF_ID_HIGH = 10'h01a;
  localparam logic [9:0] OFF_ID_LOW = 10'h01b;
  localparam logic [9:0] OFF_MEM_A = 10'h01c;
  localparam logic [9:0] OFF_MEM_B = 10'h01d;
  localparam logic [9:0] OFF_MAP_END = 10'h040;
  localparam int RESERVED_COUNT = 8;
  localparam logic [9:0] RESERVED_LIST [RESERVED_COUNT] = '{
    10'h004, 10'h005, 10'h006, 10'h007, 10'h00f, 10'h018, 10'h019, 10'h031};
  localparam int FACTORY_COUNT = 7;
  localparam logic [9:0] FACTORY_LIST [FACTORY_COUNT] = '{
    10'h014, 10'h015, 10'h016, 10'h017, 10'h036, 10'h03d, 10'h03e};
  localparam logic [3:0] BASE_RESET = 4'h0;
  localparam int BASE_LSB = 3;
  localparam int BASE_MSB = 6;
  localparam int ADDR_BASE_LSB = 11;
  localparam int ADDR_BASE_MSB = 15;
  localparam int ADDR_WIN_BIT = 10;
  // Identity fields, arbitrary values
  localparam logic [3:0] ID_MAJOR_FAMILY = 4'h1;
  localparam logic [3:0] ID_MINOR_FAMILY = 4'h2;
  localparam logic [3:0] ID_MAJOR_MASK = 4'h3;
  localparam logic [3:0] ID_MINOR_MASK = 4'h4;
  localparam logic [0:0] REGBLOCK_SIZE_CODE = 1'h0;
  localparam logic [2:0] RAM_SIZE_CODE = 3'h0;
  localparam logic [1:0] CALRAM_SIZE_CODE = 2'h1;
  localparam logic [1:0] ROM_MAPPING_CODE = 2'h3;
  localparam logic [1:0] PAGING_SPACE_CODE = 2'h3;
  typedef enum logic [2:0] {
    RBDI_KIND_NONE, RBDI_KIND_RESERVED, RBDI_KIND_FACTORY, RBDI_KIND_UNIMPL, RBDI_KIND_LIVE
  } rbdi_kind_e;
endpackage

/* rbdi_class.sv */
`timescale 1ns/1ns
// Offset classifier: reserved and factory-test slots
module rbdi_class (
  input wire logic [9:0] offset_in,
  output logic reserved_out,
  output logic factory_out
);
  logic [rbdi_pkg::RESERVED_COUNT-1:0] rsv_hit;
  logic [rbdi_pkg::FACTORY_COUNT-1:0] fac_hit;
  genvar i;
  generate
    for (i = 0; i < rbdi_pkg::RESERVED_COUNT; i++) begin : g_rsv
      assign rsv_hit[i] = (offset_in == rbdi_pkg::RESERVED_LIST[i]);
    end
    for (i = 0; i < rbdi_pkg::FACTORY_COUNT; i++) begin : g_fac
      assign fac_hit[i] = (offset_in == rbdi_pkg::FACTORY_LIST[i]);
    end
  endgenerate
  assign reserved_out = |rsv_hit;
  assign factory_out = |fac_hit;
endmodule // rbdi_class

/* rbdi_identity.sv */
`timescale 1ns/1ns
// Constant identity and memory-size bytes
module rbdi_identity (
  output logic [15:0] chip_identity_out,
  output logic [7:0] memory_size_info_a_out,
  output logic [7:0] memory_size_info_b_out
);
  assign chip_identity_out = {rbdi_pkg::ID_MAJOR_FAMILY, rbdi_pkg::ID_MINOR_FAMILY,
                              rbdi_pkg::ID_MAJOR_MASK, rbdi_pkg::ID_MINOR_MASK}; // [R9]
  assign memory_size_info_a_out = {rbdi_pkg::REGBLOCK_SIZE_CODE, 1'b0,
                                   rbdi_pkg::CALRAM_SIZE_CODE, 1'b0,
                                   rbdi_pkg::RAM_SIZE_CODE}; // [R11]
  assign memory_size_info_b_out = {rbdi_pkg::ROM_MAPPING_CODE, 4'h0,
                                   rbdi_pkg::PAGING_SPACE_CODE}; // [R11]
endmodule // rbdi_identity

/* rbdi_top.sv */
// Register block decoder with base relocation and identity bytes
// Behaviour
// [R1] Block relocates to any 2K boundary below 32K via four base bits.
// [R2] Upper five block address bits come from the base register; code takes bits 14:11 from it and compares bit 15 to zero.
// [R3] Block spans 1K; register address is base plus offset.
// [R4] Reserved slots read zero; writes change nothing.
// [R5] Unimplemented slots read a fixed value; writes have no effect.
// [R6] Factory-test slots read fixed value; writes ignored in normal modes.
// [R7] Software in special modes should not write factory-test slots.
// [R8] Sixteen-bit identity readable as two bytes anytime; writes ignored.
// [R9] Identity packs family, minor family, major and minor mask fields.
// [R10] Software must not use identity low nibble for identification.
// [R11] Two memory-size bytes report the fixed strapped configuration.
// [R12] Access claimed only when top address bits match and offset in window.
`timescale 1ns/1ns
module rbdi_top (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic bus_valid_in,
  input wire logic bus_write_in,
  input wire logic [15:0] bus_addr_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic special_mode_in,
  output logic bus_claim_out,
  output logic [7:0] bus_rdata_out,
  output logic bus_rvalid_out,
  output logic [3:0] base_select_out,
  output logic factory_write_out,
  output logic [9:0] peripheral_offset_out,
  output logic peripheral_sel_out
);
  logic [3:0] base_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic fwr_q;
  logic [9:0] offset;
  logic hit;
  logic is_rsv;
  logic is_fac;
  logic [15:0] ident;
  logic [7:0] mem_a;
  logic [7:0] mem_b;
  rbdi_pkg::rbdi_kind_e kind;
  logic [7:0] rd_d;

  rbdi_class u_class (
    .offset_in(offset),
    .reserved_out(is_rsv),
    .factory_out(is_fac)
  );

  rbdi_identity u_ident (
    .chip_identity_out(ident),
    .memory_size_info_a_out(mem_a),
    .memory_size_info_b_out(mem_b)
  );

  assign offset = bus_addr_in[rbdi_pkg::ADDR_WIN_BIT-1:0]; // [R3]
  // Bit 15 compared against zero keeps the block below 32K
  assign hit = bus_valid_in
    && (bus_addr_in[rbdi_pkg::ADDR_BASE_MSB:rbdi_pkg::ADDR_BASE_LSB] == {1'b0, base_q})
    && !bus_addr_in[rbdi_pkg::ADDR_WIN_BIT]; // [R12] [R2] [R1]
  assign bus_claim_out = hit;

  always_comb begin
    kind = rbdi_pkg::RBDI_KIND_NONE;
    if (hit) begin
      if (is_rsv) begin
        kind = rbdi_pkg::RBDI_KIND_RESERVED;
      end else if (is_fac) begin
        kind = rbdi_pkg::RBDI_KIND_FACTORY;
      end else if (offset >= rbdi_pkg::OFF_MAP_END) begin
        kind = rbdi_pkg::RBDI_KIND_UNIMPL;
      end else begin
        kind = rbdi_pkg::RBDI_KIND_LIVE;
      end
    end
  end

  // Offsets below the map end not owned here go to the peripheral bus
  always_comb begin
    peripheral_sel_out = 1'b0;
    if (kind == rbdi_pkg::RBDI_KIND_LIVE) begin
      peripheral_sel_out = !(offset == rbdi_pkg::OFF_BASE || offset == rbdi_pkg::OFF_ID_HIGH
        || offset == rbdi_pkg::OFF_ID_LOW || offset == rbdi_pkg::OFF_MEM_A
        || offset == rbdi_pkg::OFF_MEM_B);
    end
  end
  assign peripheral_offset_out = offset;

  always_comb begin
    rd_d = rbdi_pkg::RESERVED_READ;
    unique case (kind)
      rbdi_pkg::RBDI_KIND_NONE: rd_d = rbdi_pkg::RESERVED_READ;
      rbdi_pkg::RBDI_KIND_RESERVED: rd_d = rbdi_pkg::RESERVED_READ; // [R4]
      rbdi_pkg::RBDI_KIND_FACTORY: rd_d = rbdi_pkg::UNPRED_READ; // [R6]
      rbdi_pkg::RBDI_KIND_UNIMPL: rd_d = rbdi_pkg::UNPRED_READ; // [R5]
      rbdi_pkg::RBDI_KIND_LIVE: begin
        if (offset == rbdi_pkg::OFF_BASE) begin
          rd_d = 8'h00;
          rd_d[rbdi_pkg::BASE_MSB:rbdi_pkg::BASE_LSB] = base_q;
        end else if (offset == rbdi_pkg::OFF_ID_HIGH) begin
          rd_d = ident[15:8]; // [R8]
        end else if (offset == rbdi_pkg::OFF_ID_LOW) begin
          rd_d = ident[7:0]; // [R8]
        end else if (offset == rbdi_pkg::OFF_MEM_A) begin
          rd_d = mem_a; // [R11]
        end else if (offset == rbdi_pkg::OFF_MEM_B) begin
          rd_d = mem_b; // [R11]
        end
      end
    endcase
  end

  // Only the base register accepts writes; all other owned slots drop them
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      base_q <= rbdi_pkg::BASE_RESET;
    end else if (kind == rbdi_pkg::RBDI_KIND_LIVE && bus_write_in
                 && offset == rbdi_pkg::OFF_BASE) begin
      base_q <= bus_wdata_in[rbdi_pkg::BASE_MSB:rbdi_pkg::BASE_LSB]; // [R1] [R4] [R5] [R8]
    end
  end
  assign base_select_out = base_q;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= hit && !bus_write_in;
      if (hit && !bus_write_in) begin
        rdata_q <= rd_d;
      end
    end
  end
  assign bus_rdata_out = rdata_q;
  assign bus_rvalid_out = rvalid_q;

  // Flags a special-mode factory write; normal-mode writes are silent
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      fwr_q <= 1'b0;
    end else begin
      fwr_q <= kind == rbdi_pkg::RBDI_KIND_FACTORY && bus_write_in && special_mode_in; // [R6] [R7]
    end
  end
  assign factory_write_out = fwr_q;
endmodule // rbdi_top

/* rbdi_top_properties.sv */
// Port checker for the register block decoder
`timescale 1ns/1ns
module rbdi_top_properties (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic bus_valid_in,
  input wire logic bus_write_in,
  input wire logic [15:0] bus_addr_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic special_mode_in,
  input wire logic bus_claim_out,
  input wire logic [7:0] bus_rdata_out,
  input wire logic bus_rvalid_out,
  input wire logic [3:0] base_select_out,
  input wire logic factory_write_out,
  input wire logic [9:0] peripheral_offset_out,
  input wire logic peripheral_sel_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wire rd = bus_claim_out && !bus_write_in;
  wire bw = bus_claim_out && bus_write_in && peripheral_offset_out == 10'h011;
  a_claim_decode: assert property (bus_claim_out == (bus_valid_in &&
    !bus_addr_in[10] && bus_addr_in[15:11] == {1'b0, base_select_out})) else $error("claim");
  a_read_answer: assert property (rd |=> bus_rvalid_out) else $error("no answer");
  a_rdata_hold: assert property (!rd |=> $stable(bus_rdata_out)) else $error("rdata");
  a_base_write: assert property (bw |=> {1'b0, base_select_out, 3'h0} ==
    ($past(bus_wdata_in) & 8'h78)) else $error("base write");
  a_base_hold: assert property (!bw |=> $stable(base_select_out)) else $error("base");
  a_id_high: assert property (rd && peripheral_offset_out == 10'h01a |=>
    bus_rdata_out == 8'h12) else $error("id high");
  a_id_low: assert property (rd && peripheral_offset_out == 10'h01b |=>
    bus_rdata_out == 8'h34) else $error("id low");
  a_factory_pulse: assert property (factory_write_out |->
    $past(bus_claim_out && bus_write_in && special_mode_in && peripheral_offset_out inside
    {[10'h014:10'h017], 10'h036, 10'h03d, 10'h03e})) else $error("factory");
  a_factory_quiet: assert property (bus_claim_out && bus_write_in
    && !special_mode_in |=> !factory_write_out) else $error("factory normal");
  a_mem_size: assert property (rd && peripheral_offset_out == 10'h01c |=>
    bus_rdata_out == 8'h10) else $error("memory size");
  a_offset_pass: assert property (peripheral_offset_out == bus_addr_in[9:0])
    else $error("offset");
  // Owned, reserved and factory slots never reach the peripheral side
  a_periph_sel: assert property (peripheral_sel_out == (bus_claim_out &&
    peripheral_offset_out < 10'h040 && !(peripheral_offset_out inside {10'h004, 10'h005,
    10'h006, 10'h007, 10'h00f, 10'h011, [10'h014:10'h01d], 10'h031, 10'h036, 10'h03d,
    10'h03e}))) else $error("peripheral select");
  c_read: cover property (rd);
  c_base: cover property (bw);
  c_factory: cover property (factory_write_out);
  c_periph: cover property (peripheral_sel_out);
endmodule // rbdi_top_properties
bind rbdi_top rbdi_top_properties u_props (.*);

/* rbdi_core_model.sv */
// Processor core model issuing register block accesses
`timescale 1ns/1ns
module rbdi_core_model (
  input wire logic clk_in,
  input wire logic claim_in,
  input wire logic rvalid_in,
  input wire logic [7:0] rdata_in,
  output logic valid_out,
  output logic write_out,
  output logic [15:0] addr_out,
  output logic [7:0] wdata_out
);
  initial begin
    valid_out = 1'b0;
    write_out = 1'b0;
    addr_out = 16'h0000;
    wdata_out = 8'h00;
  end
  // Identity low nibble is never used to pick behaviour
  // Factory slots get special-mode writes only when the bench asks
  task automatic acc(input logic we, input logic [15:0] a, input logic [7:0] d,
      output logic c, output logic v, output logic [7:0] q);
    @(posedge clk_in);
    valid_out <= 1'b1;
    write_out <= we;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    c = claim_in;
    valid_out <= 1'b0;
    // Released lines flip so a stale value never looks valid
    addr_out <= ~a;
    wdata_out <= ~d;
    #1;
    v = rvalid_in;
    q = rdata_in;
  endtask
endmodule // rbdi_core_model

/* rbdi_top_tb.sv */
// Testbench for the register block decoder
`timescale 1ns/1ns
module rbdi_top_tb;
  logic ref_clk_in, rst_in, special_mode_in, bus_valid_in, bus_write_in, c, v;
  logic bus_claim_out, bus_rvalid_out, factory_write_out, peripheral_sel_out;
  logic [15:0] bus_addr_in;
  logic [7:0] bus_wdata_in, bus_rdata_out, q;
  logic [3:0] base_select_out;
  logic [9:0] peripheral_offset_out;
  logic [15:0] far [3] = '{16'h001a, 16'h7c1a, 16'hf81a};
  int errors = 0;
  int compares = 0;
  rbdi_top dut (.*);
  rbdi_core_model core (.clk_in(ref_clk_in), .claim_in(bus_claim_out),
    .rvalid_in(bus_rvalid_out), .rdata_in(bus_rdata_out), .valid_out(bus_valid_in),
    .write_out(bus_write_in), .addr_out(bus_addr_in), .wdata_out(bus_wdata_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    core.acc(1'b0, a, 8'h00, c, v, q);
    chk({6'h0, c, v}, 8'h03);
    chk(q, exp);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    core.acc(1'b1, a, d, c, v, q);
    chk({6'h0, c, v}, 8'h02);
    chk({7'h0, factory_write_out}, {7'h0, special_mode_in});
  endtask
  task automatic close_out;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    rst_in = 1'b1;
    special_mode_in = 1'b0;
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(16'h0011, 8'h00);
    wr(16'h001a, 8'h00);
    rd(16'h001a, 8'h12);
    rd(16'h001b, 8'h34);
    rd(16'h001c, 8'h10);
    rd(16'h001d, 8'hc3);
    for (int i = 0; i < rbdi_pkg::RESERVED_COUNT; i++) begin
      wr({6'h0, rbdi_pkg::RESERVED_LIST[i]}, 8'hff);
      rd({6'h0, rbdi_pkg::RESERVED_LIST[i]}, 8'h00);
    end
    for (int i = 0; i < rbdi_pkg::FACTORY_COUNT; i++) begin
      wr({6'h0, rbdi_pkg::FACTORY_LIST[i]}, 8'hff);
      rd({6'h0, rbdi_pkg::FACTORY_LIST[i]}, 8'h00);
    end
    wr(16'h0200, 8'hff);
    rd(16'h0200, 8'h00);
    rd(16'h0011, 8'h00);
    wr(16'h0011, 8'h08);
    rd(16'h0811, 8'h08);
    wr(16'h0811, 8'hff);
    rd(16'h7811, 8'h78);
    rd(16'h781a, 8'h12);
    rd(16'h7800, 8'h00);
    foreach (far[i]) begin
      core.acc(1'b0, far[i], 8'h00, c, v, q);
      chk({6'h0, c, v}, 8'h00);
    end
    special_mode_in <= 1'b1;
    wr(16'h7814, 8'h5a);
    special_mode_in <= 1'b0;
    rst_in <= 1'b1;
    // Two edges so the checker sees the cleared state before reset drops
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(16'h0011, 8'h00);
    close_out();
  end
endmodule // rbdi_top_tb
